/* File: hdl/qrw_defines.vh */
// Constants for the quad read, burst wrap and software reset sequencer.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef QRW_DEFINES_VH
`define QRW_DEFINES_VH

// Opcodes
`define QRW_OP_WORD_QREAD 8'he7
`define QRW_OP_OCTAL_QREAD 8'he3
`define QRW_OP_SET_WRAP 8'h77
`define QRW_OP_CRM_RESET 8'hff
`define QRW_OP_RST_ENABLE 8'h66
`define QRW_OP_RST 8'h99

// Field positions and values
`define QRW_CONT_HI 5
`define QRW_CONT_LO 4
`define QRW_CONT_KEEP 2'b10
`define QRW_CONT_RESET 8'h00
`define QRW_WRAP_RESET 3'b001
`define QRW_WRAP_DIS_BIT 0
`define QRW_WRAP_LEN_HI 2
`define QRW_WRAP_LEN_LO 1
`define QRW_WRAP_BASE 24'h000008

// Phase lengths in serial clocks
`define QRW_CMD_CLKS 5'h08
`define QRW_ADDR_CLKS 5'h06
`define QRW_MODE_CLKS 5'h02
`define QRW_WRAP_CLKS 5'h08

// Timing
`define QRW_CLK_NS 5
`define QRW_T_RCH_NS 3
`define QRW_T_RST_NS 30000
`define QRW_RCH_CYC_RAW ((`QRW_T_RCH_NS + `QRW_CLK_NS - 1) / `QRW_CLK_NS)
`define QRW_RCH_CYC ((`QRW_RCH_CYC_RAW < 1) ? 1 : `QRW_RCH_CYC_RAW)
`define QRW_RST_CYC (`QRW_T_RST_NS / `QRW_CLK_NS)

`endif

/* File: hdl/qrw_fifo.v */
// Read data FIFO with a registered output stage.
// Assumes DEPTH is a power of two and AW is its log2.
`timescale 1ns/1ps

module qrw_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  input wire flush_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output reg in_ready_out,
  // Drain side
  output reg out_valid_out,
  output reg [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);

  localparam [AW:0] DEPTH_W = DEPTH[AW:0];

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;

  wire push = in_valid_in & in_ready_out;
  wire load = (count_r != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);
  wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end
    else if (flush_in)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (load)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      count_r <= count_nxt;
      in_ready_out <= (count_nxt < DEPTH_W);
      if (load)
      begin
        out_valid_out <= 1'b1;
        out_data_out <= mem_r[rd_ptr_r];
      end
      else if (out_ready_in)
        out_valid_out <= 1'b0;
    end
  end

  // Storage, no reset needed
  always @(posedge clk_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_in;
  end

endmodule // qrw_fifo

/* File: hdl/qrw_core.v */
// Quad I/O read, burst wrap and software reset command sequencer.
// Assumes SPI mode 0 host pins, sampled on mclk_in; array behind mem_* ports.
//
// Function
// RULE1: Host gives even address for word quad read; two dummy clocks by default.
// RULE2: Both quad reads and wrap setting accepted only while quad_io_enable is set; continuous mode reads start without checking it.
// RULE3: Eight mode bits follow the address; upper nibble decides next opcode need.
// RULE4: Mode bits five:four equal 10 means next transaction starts with address.
// RULE5: Any other mode value means next transaction needs a full opcode.
// RULE6: Host may clock FFh on IO0 to leave continuous read mode.
// RULE7: Host releases IO lines before the first data falling edge.
// RULE8: Continuous read mode reset command clears all eight mode bits.
// RULE9: Word quad read dummy clock count comes from dummy_cycle_field.
// RULE10: Sixteen-byte aligned quad read has no dummy clocks at all.
// RULE11: Wrap command: opcode, 24 dummy bits, 8 wrap bits; keep bits six:four.
// RULE12: Wrap length codes select 8,16,32,64 bytes; disable bit stops wrapping.
// RULE13: Wrapped read starts at address, wraps at section end until deselect.
// RULE14: Stored wrap bits apply to all later quad reads until rewritten.
// RULE15: Power-on sets wrap disable bit to one.
// RULE16: Software reset clears mode bits, wrap bits and other volatile state.
// RULE17: Host restarts any operation interrupted by software reset.
// RULE18: Software reset is ignored during deep power-down.
// RULE19: Reset needs enable then reset command; host waits recovery time after.
// RULE20: Reset runs only if chip select rises after the hold delay.
// RULE21: Any command other than reset after enable cancels the enable.
// RULE22: Address, mode bits and data move four bits per clock.
`timescale 1ns/1ps
`include "qrw_defines.vh"

module qrw_core #(
  parameter RST_CYC = `QRW_RST_CYC,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Serial pins
  input wire cs_b_in,
  input wire sclk_in,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_out,
  // Configuration and device state
  input wire quad_io_enable_in,
  input wire [3:0] dummy_cycle_field_in,
  input wire deep_powerdown_in,
  // Array read port
  output reg mem_req_out,
  output reg [23:0] mem_addr_out,
  input wire mem_valid_in,
  input wire [7:0] mem_data_in,
  output wire mem_ready_out,
  // Status
  output reg [7:0] continuous_read_bits_out,
  output reg [2:0] burst_wrap_bits_out,
  output reg soft_reset_out,
  output reg reset_busy_out
);

  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_MODE = 3'd3;
  localparam ST_DUMMY = 3'd4;
  localparam ST_DATA = 3'd5;
  localparam ST_WRAP = 3'd6;
  localparam ST_SKIP = 3'd7;

  localparam integer RCH_CYC_I = `QRW_RCH_CYC;
  localparam [3:0] RCH_CYC = RCH_CYC_I[3:0];
  localparam [15:0] RST_CYC_W = RST_CYC[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg cs_s1_r;
  reg cs_s2_r;
  reg cs_d_r;
  reg sck_s1_r;
  reg sck_s2_r;
  reg sck_d_r;
  reg [3:0] io_s1_r;
  reg [3:0] io_s2_r;

  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= cs_b_in;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sck_s1_r <= sclk_in;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
    end
  end

  // IO line synchronisers, one pair per line
  genvar io_i;
  generate
    for (io_i = 0; io_i < 4; io_i = io_i + 1)
    begin : g_io_sync
      always @(posedge mclk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          io_s1_r[io_i] <= 1'b0;
          io_s2_r[io_i] <= 1'b0;
        end
        else
        begin
          io_s1_r[io_i] <= io_in[io_i];
          io_s2_r[io_i] <= io_s1_r[io_i];
        end
      end
    end
  endgenerate

  // Pin edges; serial clock edges count only while selected
  wire cs_fall = cs_d_r & ~cs_s2_r;
  wire cs_rise = ~cs_d_r & cs_s2_r;
  wire sck_rise = ~cs_s2_r & sck_s2_r & ~sck_d_r;
  wire sck_fall = ~cs_s2_r & ~sck_s2_r & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  reg [2:0] state_r;
  reg [4:0] cnt_r;
  reg [23:0] shift_r;
  reg octal_r;
  reg rst_en_r;
  reg rst_arm_r;
  reg [3:0] hold_cnt_r;
  reg [15:0] busy_cnt_r;
  reg nib_hi_r;
  reg fifo_flush_r;

  wire [7:0] opcode = {shift_r[6:0], io_s2_r[0]};
  wire [7:0] mode_byte = {shift_r[3:0], io_s2_r};
  wire [23:0] addr_full = {shift_r[19:0], io_s2_r};
  wire cont_keep = (continuous_read_bits_out[`QRW_CONT_HI:`QRW_CONT_LO] == `QRW_CONT_KEEP);
  // Reset armed by 99h after 66h, fired at cs rise
  wire hold_ok = (hold_cnt_r >= RCH_CYC);
  wire do_soft_rst = cs_rise & rst_arm_r & hold_ok & ~deep_powerdown_in; // RULE18 RULE20

  // Address step, inside an aligned section unless the wrap disable bit is set
  wire [1:0] wrap_len = burst_wrap_bits_out[`QRW_WRAP_LEN_HI:`QRW_WRAP_LEN_LO];
  wire [23:0] wrap_mask = (`QRW_WRAP_BASE << wrap_len) - 24'h000001; // RULE12
  wire [23:0] addr_inc = mem_addr_out + 24'h000001;
  wire [23:0] addr_next = burst_wrap_bits_out[`QRW_WRAP_DIS_BIT] ? addr_inc :
    ((mem_addr_out & ~wrap_mask) | (addr_inc & wrap_mask)); // RULE13 RULE14

  // FIFO hookup
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop = sck_fall & (state_r == ST_DATA) & ~nib_hi_r;
  wire fifo_push_ok = mem_valid_in & mem_req_out;

  qrw_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .flush_in(fifo_flush_r),
    .in_valid_in(fifo_push_ok),
    .in_data_in(mem_data_in),
    .in_ready_out(mem_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      shift_r <= 24'h000000;
      octal_r <= 1'b0;
      rst_en_r <= 1'b0;
      rst_arm_r <= 1'b0;
      hold_cnt_r <= 4'h0;
      busy_cnt_r <= 16'h0000;
      nib_hi_r <= 1'b1;
      fifo_flush_r <= 1'b1;
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
      mem_req_out <= 1'b0;
      mem_addr_out <= 24'h000000;
      continuous_read_bits_out <= `QRW_CONT_RESET;
      burst_wrap_bits_out <= `QRW_WRAP_RESET; // RULE15
      soft_reset_out <= 1'b0;
      reset_busy_out <= 1'b0;
    end
    else
    begin
      soft_reset_out <= 1'b0;
      fifo_flush_r <= cs_s2_r;
      // Recovery window, new transactions skipped
      if (busy_cnt_r != 16'h0000)
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      reset_busy_out <= (busy_cnt_r > 16'h0001) | do_soft_rst;
      if (rst_arm_r & ~hold_ok)
        hold_cnt_r <= hold_cnt_r + 4'h1;
      // Fetch address steps once per accepted byte
      if (mem_req_out & fifo_push_ok & mem_ready_out)
        mem_addr_out <= addr_next;

      if (cs_s2_r)
      begin
        state_r <= ST_IDLE;
        io_oe_out <= 4'h0;
        mem_req_out <= 1'b0;
        nib_hi_r <= 1'b1;
        cnt_r <= 5'h00;
        if (cs_rise)
          rst_arm_r <= 1'b0;
        if (do_soft_rst)
        begin
          continuous_read_bits_out <= `QRW_CONT_RESET; // RULE16
          burst_wrap_bits_out <= `QRW_WRAP_RESET; // RULE16
          rst_en_r <= 1'b0;
          soft_reset_out <= 1'b1;
          busy_cnt_r <= RST_CYC_W;
        end
      end
      else if (cs_fall)
      begin
        cnt_r <= 5'h00;
        if (busy_cnt_r != 16'h0000)
          state_r <= ST_SKIP;
        else if (cont_keep)
        begin
          state_r <= ST_ADDR; // RULE4
          rst_en_r <= 1'b0; // RULE21
        end
        else
          state_r <= ST_CMD; // RULE5
      end
      else if (sck_rise)
      begin
        rst_arm_r <= 1'b0;
        cnt_r <= cnt_r + 5'h01;
        case (state_r)
          ST_CMD:
          begin
            shift_r <= {shift_r[22:0], io_s2_r[0]};
            if (cnt_r == `QRW_CMD_CLKS - 5'h01)
            begin
              cnt_r <= 5'h00;
              state_r <= ST_SKIP;
              rst_en_r <= (opcode == `QRW_OP_RST_ENABLE) & ~deep_powerdown_in; // RULE21
              if (opcode == `QRW_OP_RST && rst_en_r)
              begin
                rst_arm_r <= 1'b1; // RULE19
                hold_cnt_r <= 4'h0;
              end
              if (quad_io_enable_in && (opcode == `QRW_OP_WORD_QREAD ||
                  opcode == `QRW_OP_OCTAL_QREAD)) // RULE2
              begin
                state_r <= ST_ADDR;
                octal_r <= (opcode == `QRW_OP_OCTAL_QREAD);
              end
              else if (quad_io_enable_in && opcode == `QRW_OP_SET_WRAP) // RULE2
                state_r <= ST_WRAP;
              else if (opcode == `QRW_OP_CRM_RESET)
                continuous_read_bits_out <= `QRW_CONT_RESET; // RULE8
            end
          end
          ST_ADDR:
          begin
            shift_r <= addr_full; // RULE22
            if (cnt_r == `QRW_ADDR_CLKS - 5'h01)
            begin
              cnt_r <= 5'h00;
              state_r <= ST_MODE;
              mem_addr_out <= addr_full;
              mem_req_out <= 1'b1;
            end
          end
          ST_MODE:
          begin
            shift_r <= {shift_r[19:0], io_s2_r};
            if (cnt_r == `QRW_MODE_CLKS - 5'h01)
            begin
              cnt_r <= 5'h00;
              continuous_read_bits_out <= mode_byte; // RULE3
              if (octal_r || dummy_cycle_field_in == 4'h0)
                state_r <= ST_DATA; // RULE10
              else
                state_r <= ST_DUMMY;
            end
          end
          ST_DUMMY:
          begin
            if (cnt_r == {1'b0, dummy_cycle_field_in} - 5'h01) // RULE9 RULE1
            begin
              cnt_r <= 5'h00;
              state_r <= ST_DATA;
            end
          end
          ST_WRAP:
          begin
            shift_r <= {shift_r[19:0], io_s2_r};
            if (cnt_r == `QRW_WRAP_CLKS - 5'h01)
            begin
              cnt_r <= 5'h00;
              state_r <= ST_SKIP;
              burst_wrap_bits_out <= shift_r[2:0]; // RULE11 RULE14
            end
          end
          default:
            cnt_r <= 5'h00;
        endcase
      end
      else if (sck_fall && state_r == ST_DATA)
      begin
        // Nibble out, high half of each byte first
        io_oe_out <= 4'hf;
        nib_hi_r <= ~nib_hi_r;
        if (nib_hi_r)
          io_out <= fifo_valid ? fifo_data[7:4] : 4'h0; // RULE22
        else
          io_out <= fifo_valid ? fifo_data[3:0] : 4'h0; // RULE22
      end
    end
  end

endmodule // qrw_core

/* File: tb/qrw_host_model.sv */
// Host controller model driving cs, serial clock and four IO lines.
// Assumes mode 0 framing and a serial clock of 34 system clocks.
`timescale 1ns/1ps

module qrw_host_model (
  // Clock
  input wire mclk_in,
  // Device drive
  input wire [3:0] io_out_in,
  input wire [3:0] io_oe_in,
  // Pins
  output reg cs_b_out = 1'b1,
  output reg sclk_out = 1'b0,
  output wire [3:0] io_in_out
);
  reg [3:0] val_r = 4'h0;
  reg [3:0] oe_r = 4'h0;
  reg [3:0] last_r = 4'h0;
  // Undriven lines toggle each cycle
  assign io_in_out = (io_oe_in & io_out_in) | (~io_oe_in & oe_r & val_r)
    | (~io_oe_in & ~oe_r & ~last_r);
  always @(posedge mclk_in)
    last_r <= io_in_out;
  task wait_n(input integer n);
    repeat (n) @(posedge mclk_in);
  endtask
  // One serial clock; lines released after the rise
  task tick(input [3:0] m, input [3:0] v, output [3:0] rd);
    begin
      @(posedge mclk_in);
      oe_r <= m;
      val_r <= v;
      wait_n(16);
      sclk_out <= 1'b1;
      @(posedge mclk_in);
      rd = io_in_out;
      wait_n(8);
      oe_r <= 4'h0;
      wait_n(8);
      sclk_out <= 1'b0;
    end
  endtask
  task send(input [31:0] w, input integer n, input quad);
    integer i;
    reg [3:0] d;
    for (i = 0; i < n; i = i + 1)
      if (quad)
        tick(4'hf, w[31-4*i -: 4], d);
      else
        tick(4'h1, {3'h0, w[31-i]}, d);
  endtask
  task rd_byte(output [7:0] b);
    reg [3:0] h;
    reg [3:0] l;
    begin
      tick(4'h0, 4'h0, h);
      tick(4'h0, 4'h0, l);
      b = {h, l};
    end
  endtask
  task sel(input act);
    begin
      @(posedge mclk_in);
      cs_b_out <= ~act;
      wait_n(8);
    end
  endtask
endmodule // qrw_host_model

/* File: tb/qrw_core_props.sv */
// Checker for the sequencer core; sees its ports only.
// Assumes the bind in the bench top hands on RST_CYC.
`timescale 1ns/1ps

module qrw_core_props #(
  parameter RST_CYC = 6000,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // Pins and configuration
  input wire cs_b_in,
  input wire sclk_in,
  input wire [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe_out,
  input wire quad_io_enable_in,
  input wire [3:0] dummy_cycle_field_in,
  input wire deep_powerdown_in,
  // Array port
  input wire mem_req_out,
  input wire [23:0] mem_addr_out,
  input wire mem_valid_in,
  input wire [7:0] mem_data_in,
  input wire mem_ready_out,
  // Status
  input wire [7:0] continuous_read_bits_out,
  input wire [2:0] burst_wrap_bits_out,
  input wire soft_reset_out,
  input wire reset_busy_out
);
  wire take = mem_req_out && mem_valid_in && mem_ready_out;
  wire [23:0] sec_m = (24'h8 << burst_wrap_bits_out[2:1]) - 24'h1;
  reg [15:0] busy_r;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  always @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
      busy_r <= 16'h0;
    else
      busy_r <= reset_busy_out ? busy_r + 16'h1 : 16'h0;
  ////////////////////////////////////////////////////////////
  oe_whole_a: assert property (io_oe_out == 4'h0 || io_oe_out == 4'hf)
    else $error("io enables split");
  quad_off_a: assert property (!quad_io_enable_in [*8] |-> io_oe_out == 4'h0)
    else $error("drive with quad off");
  por_wrap_a: assert property ($rose(rst_b_in) |-> burst_wrap_bits_out == 3'b001)
    else $error("wrap bits after reset");
  sreset_clear_a: assert property (soft_reset_out |=>
    burst_wrap_bits_out == 3'b001 && continuous_read_bits_out == 8'h00)
    else $error("state kept over soft reset");
  busy_len_a: assert property (busy_r <= RST_CYC + 2)
    else $error("recovery too long");
  sreset_cs_a: assert property (soft_reset_out |-> cs_b_in && $past(cs_b_in))
    else $error("soft reset while selected");
  dpd_block_a: assert property (deep_powerdown_in && $past(deep_powerdown_in)
    |-> !soft_reset_out) else $error("soft reset in power-down");
  addr_step_a: assert property (take && burst_wrap_bits_out[0]
    |=> mem_addr_out == $past(mem_addr_out) + 24'h1) else $error("address step");
  addr_wrap_a: assert property (take && !burst_wrap_bits_out[0] |=>
    ((mem_addr_out ^ $past(mem_addr_out)) & ~sec_m) == 24'h0 &&
    (mem_addr_out & sec_m) == (($past(mem_addr_out) + 24'h1) & sec_m))
    else $error("address wrap");
  cover property (soft_reset_out);
  cover property (take && !burst_wrap_bits_out[0]);
  cover property (mem_req_out && !mem_ready_out);
endmodule // qrw_core_props

/* File: tb/qrw_core_test.sv */
// Self-checking bench for the quad read, wrap and soft reset core.
// Assumes the host model and an array stub answering every other cycle.
`timescale 1ns/1ps

module qrw_core_test;
  typedef struct {logic [7:0] op; logic [23:0] a; logic [7:0] m;
    logic [3:0] d; logic [2:0] w; int n;} qrw_row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic qe;
  logic dpd;
  logic [3:0] dcf;
  logic mem_valid = 1'b0;
  logic [7:0] mem_data = 8'h00;
  logic [2:0] wrap = 3'b001;
  logic oe_seen = 1'b0;
  wire cs_b, sclk, mem_req, mem_ready, srst, busy;
  wire [3:0] io_in, io_out, io_oe;
  wire [23:0] mem_addr;
  wire [7:0] crb;
  wire [2:0] bwb;
  int err_count = 0;
  int tests_run = 0;
  int sr_cnt = 0;
  int cyc = 0;
  // Even word read addresses, aligned sixteen-byte read addresses
  qrw_row_t rows [7] = '{'{8'he3, 24'h000100, 8'h00, 4'h2, 3'h1, 4},
    '{8'he7, 24'h0001fa, 8'hc5, 4'h2, 3'h0, 10}, '{8'he7, 24'h00023e, 8'h3f, 4'h0, 3'h2, 6},
    '{8'he3, 24'h000350, 8'h1f, 4'hf, 3'h4, 18}, '{8'he7, 24'h0004be, 8'h0c, 4'h3, 3'h6, 4},
    '{8'he3, 24'h0004b0, 8'h00, 4'ha, 3'h6, 18}, '{8'he7, 24'h0005fe, 8'h00, 4'h2, 3'h7, 4}};
  qrw_core #(.RST_CYC(20)) dut (.mclk_in(mclk), .rst_b_in(rst_b), .cs_b_in(cs_b),
    .sclk_in(sclk), .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe),
    .quad_io_enable_in(qe), .dummy_cycle_field_in(dcf), .deep_powerdown_in(dpd),
    .mem_req_out(mem_req), .mem_addr_out(mem_addr), .mem_valid_in(mem_valid),
    .mem_data_in(mem_data), .mem_ready_out(mem_ready), .continuous_read_bits_out(crb),
    .burst_wrap_bits_out(bwb), .soft_reset_out(srst), .reset_busy_out(busy));
  qrw_host_model host (.mclk_in(mclk), .io_out_in(io_out), .io_oe_in(io_oe),
    .cs_b_out(cs_b), .sclk_out(sclk), .io_in_out(io_in));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  // Array stub and monitor
  always @(posedge mclk)
  begin
    mem_valid <= mem_req && !mem_valid;
    mem_data <= mem_addr[7:0] ^ 8'h5a;
    cyc++;
    if (io_oe !== 4'h0)
      oe_seen = 1'b1;
    if (srst === 1'b1)
      sr_cnt++;
    if (cyc == 60000)
    begin
      err_count++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  function [23:0] nxt(input [23:0] a);
    reg [23:0] m;
    begin
      m = (24'h8 << wrap[2:1]) - 24'h1;
      nxt = wrap[0] ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
    end
  endfunction
  task cmd(input [7:0] op, input [31:0] w, input integer n);
    begin
      host.sel(1'b1);
      host.send({op, 24'h0}, 8, 1'b0);
      host.send(w, n, 1'b1);
      host.sel(1'b0);
    end
  endtask
  task setwrap(input [2:0] w);
    begin
      cmd(8'h77, {24'h0, 1'b1, w, 4'hf}, 8);
      wrap = w;
      check(bwb, w, "wrap");
    end
  endtask
  task qread(input [7:0] op, input [23:0] a, input [7:0] m, input integer nb, input cont);
    integer i;
    reg [7:0] b;
    reg [3:0] d;
    begin
      host.sel(1'b1);
      if (!cont)
        host.send({op, 24'h0}, 8, 1'b0);
      host.send({a, m}, 8, 1'b1);
      for (i = 0; op == 8'he7 && i < dcf; i++)
        host.tick(4'h0, 4'h0, d);
      for (i = 0; i < nb; i++)
      begin
        host.rd_byte(b);
        check(b, a[7:0] ^ 8'h5a, "data");
        a = nxt(a);
      end
      host.sel(1'b0);
      check(crb, m, "mode");
      check(mem_req, 1'b0, "fetch");
    end
  endtask
  task idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(posedge mclk);
    check(busy, 1'b0, "busy");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    qe <= 1'b1;
    dpd <= 1'b0;
    dcf <= 4'h2;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    check(bwb, 3'b001, "wrap");
    check(mem_ready, 1'b1, "ready");
    foreach (rows[i])
    begin
      if (rows[i].w !== wrap)
        setwrap(rows[i].w);
      dcf <= rows[i].d;
      qread(rows[i].op, rows[i].a, rows[i].m, rows[i].n, 1'b0);
    end
    // Continuous mode and its exits
    qread(8'he3, 24'h000700, 8'h2a, 2, 1'b0);
    qread(8'he3, 24'h000710, 8'hf0, 2, 1'b1);
    qread(8'he3, 24'h000720, 8'h2a, 2, 1'b0);
    cmd(8'hff, 32'h0, 0);
    check(crb[4], 1'b1, "mode exit");
    cmd(8'hff, 32'h0, 0);
    check(crb, 8'h00, "mode");
    qread(8'he3, 24'h000730, 8'h05, 2, 1'b0);
    // Soft reset and its refusals
    cmd(8'h66, 32'h0, 0);
    cmd(8'h99, 32'h0, 0);
    check(sr_cnt, 1, "resets");
    check(bwb, 3'b001, "wrap");
    check(crb, 8'h00, "mode");
    wrap = 3'b001;
    idle;
    setwrap(3'b000);
    cmd(8'h66, 32'h0, 0);
    cmd(8'h05, 32'h0, 0);
    cmd(8'h99, 32'h0, 0);
    dpd <= 1'b1;
    cmd(8'h66, 32'h0, 0);
    cmd(8'h99, 32'h0, 0);
    dpd <= 1'b0;
    cmd(8'h66, 32'h0, 0);
    host.sel(1'b1);
    host.send({8'h99, 24'h0}, 9, 1'b0);
    host.sel(1'b0);
    check(sr_cnt, 1, "resets");
    // Quad commands refused with quad enable off
    qe <= 1'b0;
    oe_seen = 1'b0;
    cmd(8'he3, 32'h00080000, 8);
    cmd(8'h77, 32'h0000003f, 8);
    check(oe_seen, 1'b0, "drive");
    check(bwb, 3'b000, "wrap");
    qe <= 1'b1;
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    check(bwb, 3'b001, "wrap");
    conclude;
  end
endmodule // qrw_core_test

bind qrw_core qrw_core_props #(.RST_CYC(RST_CYC), .FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
  props (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in), .sclk_in(sclk_in),
  .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe_out), .quad_io_enable_in(quad_io_enable_in),
  .dummy_cycle_field_in(dummy_cycle_field_in), .deep_powerdown_in(deep_powerdown_in),
  .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_valid_in(mem_valid_in),
  .mem_data_in(mem_data_in), .mem_ready_out(mem_ready_out),
  .continuous_read_bits_out(continuous_read_bits_out),
  .burst_wrap_bits_out(burst_wrap_bits_out), .soft_reset_out(soft_reset_out),
  .reset_busy_out(reset_busy_out));
